// ---- hdl/sync_port_regs.svh ----
`ifndef SYNC_PORT_REGS_SVH
`define SYNC_PORT_REGS_SVH
// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFS_CTRL 8'h14
`define OFS_STAT 8'h94
`define OFS_CTRL2 8'h91
`define OFS_BUF 8'h13
`define OFS_OWN_ADDR 8'h93
`define RST_BYTE 8'h00
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CTL_WRITE_COLLISION 7
`define CTL_OVF 6
`define CTL_EN 5
`define CTL_CKP 4
`define CTL_MODE 3:0
`define ST_SMP 7
`define ST_EDGE 6
`define C2_BUSY 4:0
// -----------------------------------------------------------------
// mode codes and protocol constants
// -----------------------------------------------------------------
`define M_I2C_S7 4'h6
`define M_I2C_S10 4'h7
`define M_I2C_M 4'h8
`define M_I2C_FW 4'hb
`define M_I2C_S7I 4'he
`define M_I2C_S10I 4'hf
`define TEN_HDR 5'h1e
`define LAST_BIT 3'h7
`define EV_START 0
`define EV_STOP 1
`define EV_BYTE 2
`define EV_NACK 3
`endif

// ---- hdl/sync_port_pkg.sv ----
package sync_port_pkg;
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_BYTE = 3'b010,
        LINK_ACK = 3'b100
    } link_phase_t;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [2:0] i2c_sy;
        logic [2:0] rise_sy;
        logic scl;
        logic sda;
        logic i2c;
        logic rise;
        link_phase_t phase;
        logic [2:0] cnt;
        logic first;
        logic [7:0] shift;
        logic [7:0] data;
        logic is_addr;
        logic [3:0] tgl;
    } link_regs_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ctrl2;
        logic input_sample_phase;
        logic clk_edge;
        logic da;
        logic stop;
        logic start;
        logic rw_slave;
        logic ua;
        logic bf;
        logic tx_active;
        logic [7:0] buffer;
        logic [7:0] own_addr;
        logic [7:0] rdata;
        logic [3:0] ev_s1;
        logic [3:0] ev_s2;
        logic [3:0] ev_s3;
        logic [3:0] ev_seen;
        logic cfg_i2c;
        logic cfg_rise;
        logic i2c_mode;
        logic slew;
        logic smbus;
        logic busy;
        logic sample_end;
        logic tx_rise;
    } port_regs_t;
endpackage

// ---- hdl/link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface link_if;
    logic [3:0] tgl;
    logic [7:0] data;
    logic is_addr;
    logic cfg_i2c;
    logic cfg_rise;
    modport tracker (output tgl, output data, output is_addr, input cfg_i2c, input cfg_rise);
    modport port (input tgl, input data, input is_addr, output cfg_i2c, output cfg_rise);
endinterface // link_if
`default_nettype wire

// ---- hdl/link_byte_tracker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sync_port_regs.svh"
module link_byte_tracker (
    // link clock and reset from the register side
    input wire logic i_link_clk,
    input wire logic i_sys_rst,
    // serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    // events towards the register side
    link_if.tracker lnk
);
    import sync_port_pkg::*;

    localparam link_regs_t LINK_RESET = '{phase: LINK_IDLE, default: '0};
    logic [2:0] rst_sy;
    logic link_rst;
    logic start_seen;
    logic stop_seen;
    logic sample;
    link_regs_t cur;
    link_regs_t next;

    // -------------------------------------------------------------
    // reset crossing: held until both late stages are low
    // -------------------------------------------------------------
    always_ff @(posedge i_link_clk) begin
        rst_sy <= {rst_sy[1:0], i_sys_rst};
    end
    assign link_rst = rst_sy[1] | rst_sy[2];

    // -------------------------------------------------------------
    // condition and bit tracking
    // -------------------------------------------------------------
    always_comb begin
        next = cur;
        next.scl_sy = {cur.scl_sy[1:0], i_scl};
        next.sda_sy = {cur.sda_sy[1:0], i_sda};
        next.i2c_sy = {cur.i2c_sy[1:0], lnk.cfg_i2c};
        next.rise_sy = {cur.rise_sy[1:0], lnk.cfg_rise};
        if (cur.scl_sy[1] == cur.scl_sy[2]) next.scl = cur.scl_sy[2];
        if (cur.sda_sy[1] == cur.sda_sy[2]) next.sda = cur.sda_sy[2];
        if (cur.i2c_sy[1] == cur.i2c_sy[2]) next.i2c = cur.i2c_sy[2];
        if (cur.rise_sy[1] == cur.rise_sy[2]) next.rise = cur.rise_sy[2];
        // data line moving while the clock is high marks a bus condition
        start_seen = cur.i2c && cur.scl && next.scl && cur.sda && !next.sda;
        stop_seen = cur.i2c && cur.scl && next.scl && !cur.sda && next.sda;
        sample = (cur.i2c || cur.rise) ? (!cur.scl && next.scl) : (cur.scl && !next.scl); // RULE2 RULE5
        if (!cur.i2c) begin
            next.first = 1'b0;
            if (cur.phase == LINK_IDLE) next.phase = LINK_BYTE;
        end
        if (start_seen) begin
            next.phase = LINK_BYTE;
            next.cnt = '0;
            next.first = 1'b1;
            next.tgl[`EV_START] = ~cur.tgl[`EV_START];
        end else if (stop_seen) begin
            next.phase = LINK_IDLE;
            next.tgl[`EV_STOP] = ~cur.tgl[`EV_STOP];
        end else if (sample) begin
            unique case (cur.phase)
                LINK_IDLE: begin
                    next.cnt = '0;
                end
                LINK_BYTE: begin
                    next.shift = {cur.shift[6:0], next.sda};
                    next.cnt = cur.cnt + 3'h1;
                    if (cur.cnt == `LAST_BIT) begin
                        next.data = {cur.shift[6:0], next.sda};
                        next.is_addr = cur.first;
                        next.tgl[`EV_BYTE] = ~cur.tgl[`EV_BYTE];
                        next.phase = cur.i2c ? LINK_ACK : LINK_BYTE;
                    end
                end
                LINK_ACK: begin
                    if (next.sda) next.tgl[`EV_NACK] = ~cur.tgl[`EV_NACK];
                    next.first = 1'b0;
                    next.phase = LINK_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (link_rst) cur <= LINK_RESET;
        else cur <= next;
    end

    assign lnk.tgl = cur.tgl;
    assign lnk.data = cur.data;
    assign lnk.is_addr = cur.is_addr;
endmodule // link_byte_tracker
`default_nettype wire

// ---- hdl/sync_serial_port_status.sv ----
// Functional notes
// RULE1: the port works either as a four-wire SPI port or a two-wire I2C port, one at a time.
// RULE2: in SPI master use the sample-phase bit picks sampling at the end or the middle of a bit.
// RULE3: software driving an SPI slave keeps the sample-phase bit at zero.
// RULE4: in I2C use the sample-phase bit turns slew limiting off when set and on when clear.
// RULE5: in SPI use the edge bit picks the transmit edge, swapped by clock polarity.
// RULE6: in I2C use the edge bit picks SMBus input levels when set, I2C levels when clear.
// RULE7: in I2C the data/address bit tells whether the last byte was data or an address.
// RULE8: the stop flag shows a stop was seen last, is zero at reset and when disabled.
// RULE9: the start flag shows a start was seen last, is zero at reset and when disabled.
// RULE10: an I2C slave keeps the read/write bit of its last matching address until start, stop or nack.
// RULE11: an I2C master shows transmit in progress in the read/write bit, which joins the busy term.
// RULE12: with 10-bit addressing the update flag asks software to rewrite the own address.
// RULE13: on reception the buffer-full flag sets on a complete byte and clears when emptied.
// RULE14: on I2C transmission the buffer-full flag stays set while the byte shifts out.
// RULE15: only the top two status bits are writable, all eight reset to zero.
// RULE16: a start clears the stop flag and a stop clears the start flag.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sync_port_regs.svh"
module sync_serial_port_status (
    // system clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    // serial link
    input wire logic I_LINK_CLK,
    input wire logic I_SCL,
    input wire logic I_SDA,
    // mode qualifiers to the pad and shift logic
    output logic O_I2C_MODE,
    output logic O_SLEW_LIMIT_EN,
    output logic O_SMBUS_LEVELS,
    output logic O_SAMPLE_AT_END,
    output logic O_TX_ON_RISING,
    output logic O_PORT_BUSY
);
    import sync_port_pkg::*;

    // -------------------------------------------------------------
    // mode decoding
    // -------------------------------------------------------------
    function automatic logic is_i2c(input logic [3:0] m);
        return (m == `M_I2C_S7) || (m == `M_I2C_S10) || (m == `M_I2C_M) ||
               (m == `M_I2C_FW) || (m == `M_I2C_S7I) || (m == `M_I2C_S10I);
    endfunction

    function automatic logic is_master(input logic [3:0] m);
        return (m == `M_I2C_M) || (m == `M_I2C_FW);
    endfunction

    function automatic logic is_ten(input logic [3:0] m);
        return (m == `M_I2C_S10) || (m == `M_I2C_S10I);
    endfunction

    // a 10-bit header carries address bits 9:8 beside the direction bit
    function automatic logic addr_match(input logic [7:0] b, input logic [7:0] own,
                                        input logic ten);
        if (ten && (b[7:3] == `TEN_HDR)) return b[2:1] == own[2:1];
        else if (ten) return b == own;
        else return b[7:1] == own[7:1];
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    port_regs_t cur;
    port_regs_t next;
    logic [3:0] ev;
    logic i2c;
    logic master;
    logic ten;
    logic en;
    logic match;
    logic rw_bit;
    logic [7:0] stat_rd;
    logic [7:0] rd_mux;

    link_if lnk ();

    link_byte_tracker u_tracker (
        .i_link_clk (I_LINK_CLK),
        .i_sys_rst (I_SYS_RST),
        .i_scl (I_SCL),
        .i_sda (I_SDA),
        .lnk (lnk.tracker)
    );

    // -------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------
    always_comb begin
        next = cur;
        i2c = is_i2c(cur.ctrl[`CTL_MODE]); // RULE1
        master = is_master(cur.ctrl[`CTL_MODE]);
        ten = is_ten(cur.ctrl[`CTL_MODE]);
        en = cur.ctrl[`CTL_EN];

        // event toggles from the link: three stages, counted once the late two agree
        next.ev_s1 = lnk.tgl;
        next.ev_s2 = cur.ev_s1;
        next.ev_s3 = cur.ev_s2;
        ev = ~(cur.ev_s2 ^ cur.ev_s3) & (cur.ev_s3 ^ cur.ev_seen);
        next.ev_seen = cur.ev_seen ^ ev;

        // link data is held for a whole byte time, so it is settled when the toggle lands
        match = addr_match(lnk.data, cur.own_addr, ten);

        rw_bit = master ? cur.tx_active : cur.rw_slave; // RULE11
        stat_rd = {cur.input_sample_phase, cur.clk_edge, cur.da, cur.stop, cur.start, rw_bit, cur.ua, cur.bf};

        unique case (I_REG_ADDR)
            `OFS_CTRL: rd_mux = cur.ctrl;
            `OFS_CTRL2: rd_mux = cur.ctrl2;
            `OFS_STAT: rd_mux = stat_rd;
            `OFS_BUF: rd_mux = cur.buffer;
            `OFS_OWN_ADDR: rd_mux = cur.own_addr;
            default: rd_mux = `RST_BYTE;
        endcase
        next.rdata = I_REG_RD ? rd_mux : `RST_BYTE;

        // software side first, so that hardware sets below win in the same cycle
        if (I_REG_WR) begin
            unique case (I_REG_ADDR)
                `OFS_CTRL: next.ctrl = I_REG_WDATA;
                `OFS_CTRL2: next.ctrl2 = I_REG_WDATA;
                `OFS_STAT: begin
                    next.input_sample_phase = I_REG_WDATA[`ST_SMP]; // RULE15
                    next.clk_edge = I_REG_WDATA[`ST_EDGE]; // RULE15
                end
                `OFS_OWN_ADDR: begin
                    next.own_addr = I_REG_WDATA;
                    next.ua = 1'b0; // RULE12
                end
                `OFS_BUF: begin
                    if (cur.tx_active) begin
                        // buffer kept intact: overwriting a byte in flight would corrupt it
                        next.ctrl[`CTL_WRITE_COLLISION] = 1'b1;
                    end else begin
                        next.buffer = I_REG_WDATA;
                        if (i2c) begin
                            next.tx_active = 1'b1; // RULE14
                            next.bf = 1'b1; // RULE14
                        end
                    end
                end
                default: begin
                    next.rdata = next.rdata;
                end
            endcase
        end
        if (I_REG_RD && (I_REG_ADDR == `OFS_BUF) && !cur.tx_active) begin
            next.bf = 1'b0; // RULE13
        end

        // bus conditions
        if (ev[`EV_START] && i2c) begin
            next.start = 1'b1; // RULE9
            next.stop = 1'b0; // RULE16
            next.rw_slave = 1'b0; // RULE10
        end
        if (ev[`EV_STOP] && i2c) begin
            next.stop = 1'b1; // RULE8
            next.start = 1'b0; // RULE16
            next.rw_slave = 1'b0; // RULE10
        end
        if (ev[`EV_NACK] && i2c) begin
            next.rw_slave = 1'b0; // RULE10
        end

        // completed bytes
        if (ev[`EV_BYTE]) begin
            if (cur.tx_active && i2c) begin
                next.tx_active = 1'b0; // RULE14
                next.bf = 1'b0; // RULE14
            end else begin
                next.buffer = lnk.data;
                if (cur.bf) next.ctrl[`CTL_OVF] = 1'b1;
                next.bf = 1'b1; // RULE13
            end
            if (i2c) begin
                next.da = !lnk.is_addr; // RULE7
                if (lnk.is_addr && !master && match) begin
                    next.rw_slave = lnk.data[0]; // RULE10
                    if (ten) next.ua = 1'b1; // RULE12
                end
            end
        end

        // a disabled port forgets the last bus condition
        if (!en) begin
            next.start = 1'b0; // RULE9
            next.stop = 1'b0; // RULE8
        end

        // qualifiers handed to the link and the pads
        next.cfg_i2c = i2c;
        next.cfg_rise = cur.input_sample_phase ? (cur.clk_edge ^ cur.ctrl[`CTL_CKP])
                                : !(cur.clk_edge ^ cur.ctrl[`CTL_CKP]); // RULE2 RULE5
        next.i2c_mode = i2c; // RULE1
        next.slew = i2c && !cur.input_sample_phase; // RULE4
        next.smbus = i2c && cur.clk_edge; // RULE6
        next.sample_end = !i2c && cur.input_sample_phase; // RULE2
        next.tx_rise = !i2c && (cur.clk_edge ^ cur.ctrl[`CTL_CKP]); // RULE5
        next.busy = i2c && master && (cur.tx_active || (|cur.ctrl2[`C2_BUSY])); // RULE11
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) cur <= '0; // RULE15
        else cur <= next;
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign lnk.cfg_i2c = cur.cfg_i2c;
    assign lnk.cfg_rise = cur.cfg_rise;
    assign O_REG_RDATA = cur.rdata;
    assign O_I2C_MODE = cur.i2c_mode;
    assign O_SLEW_LIMIT_EN = cur.slew;
    assign O_SMBUS_LEVELS = cur.smbus;
    assign O_SAMPLE_AT_END = cur.sample_end;
    assign O_TX_ON_RISING = cur.tx_rise;
    assign O_PORT_BUSY = cur.busy;
endmodule // sync_serial_port_status
`default_nettype wire

// ---- test/sync_port_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sync_port_regs.svh"
module sync_port_monitor (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] O_REG_RDATA,
    // mode qualifiers
    input wire logic O_I2C_MODE,
    input wire logic O_SLEW_LIMIT_EN,
    input wire logic O_SMBUS_LEVELS,
    input wire logic O_SAMPLE_AT_END,
    input wire logic O_TX_ON_RISING,
    input wire logic O_PORT_BUSY
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic ctl_wr, stat_wr, mapped, i2c_code;
    assign ctl_wr = I_REG_WR && I_REG_ADDR == `OFS_CTRL;
    assign stat_wr = I_REG_WR && I_REG_ADDR == `OFS_STAT;
    assign mapped = I_REG_ADDR inside {`OFS_CTRL, `OFS_STAT, `OFS_CTRL2, `OFS_BUF, `OFS_OWN_ADDR};
    assign i2c_code = I_REG_WDATA[3:0] inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
    // a status write whose effect lands while the port is in one mode or the other
    sequence stat_in_i2c;
        stat_wr ##2 O_I2C_MODE;
    endsequence
    sequence stat_in_spi;
        stat_wr ##2 !O_I2C_MODE;
    endsequence
    chk_rdata_idle: assert property (!I_REG_RD |=> O_REG_RDATA == `RST_BYTE)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (I_REG_RD && !mapped |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_mode_i2c: assert property (ctl_wr && i2c_code |-> ##2 O_I2C_MODE)
        else $error("i2c mode not entered");
    chk_mode_spi: assert property (ctl_wr && !i2c_code |-> ##2 !O_I2C_MODE)
        else $error("spi mode not entered");
    chk_slew_limit: assert property (stat_in_i2c |-> O_SLEW_LIMIT_EN != $past(I_REG_WDATA[7], 2))
        else $error("slew limit wrong");
    chk_smbus_levels: assert property (stat_in_i2c |-> O_SMBUS_LEVELS == $past(I_REG_WDATA[6], 2))
        else $error("input levels wrong");
    chk_sample_end: assert property (stat_in_spi |-> O_SAMPLE_AT_END == $past(I_REG_WDATA[7], 2))
        else $error("sample point wrong");
    chk_spi_only_out: assert property (O_I2C_MODE |-> !O_TX_ON_RISING && !O_SAMPLE_AT_END)
        else $error("spi qualifier active in i2c mode");
    chk_busy_mode: assert property (O_PORT_BUSY |-> O_I2C_MODE)
        else $error("busy outside i2c mode");
endmodule // sync_port_monitor
bind sync_serial_port_status sync_port_monitor mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .O_I2C_MODE(O_I2C_MODE),
    .O_SLEW_LIMIT_EN(O_SLEW_LIMIT_EN), .O_SMBUS_LEVELS(O_SMBUS_LEVELS),
    .O_SAMPLE_AT_END(O_SAMPLE_AT_END), .O_TX_ON_RISING(O_TX_ON_RISING),
    .O_PORT_BUSY(O_PORT_BUSY));
`default_nettype wire

// ---- test/i2c_ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_model (
    // bus lines, idle high through the pull-ups
    output var logic o_scl,
    output var logic o_sda
);
    // half bit time in ns; the bench raises it to act as a slow controller
    int half = 160;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start_cond();
        o_sda = 1'b0;
        #(half);
        o_scl = 1'b0;
        #(half);
    endtask
    task automatic stop_cond();
        o_sda = 1'b0;
        #(half);
        o_scl = 1'b1;
        #(half);
        o_sda = 1'b1;
        #(half);
    endtask
    task automatic clk_bit(input logic b);
        o_sda = b;
        #(half);
        o_scl = 1'b1;
        #(half);
        o_scl = 1'b0;
    endtask
    task automatic send_bits(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i]);
        end
    endtask
    // the acknowledging side lets go after the ninth bit, so the pull-up wins
    task automatic ack_bit(input logic a);
        clk_bit(a);
        o_sda = 1'b1;
    endtask
endmodule // i2c_ctrl_model
`default_nettype wire

// ---- test/test_sync_serial_port_status.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sync_port_regs.svh"
module test_sync_serial_port_status;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] st;
        logic [7:0] exp;
        logic [4:0] outs;
    } row_t;
    logic clk;
    logic lclk;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_s;
    logic rd_s;
    logic [7:0] rdata, v;
    logic scl, sda, busy;
    logic [4:0] outs;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] probe [6] = '{8'h14, 8'h94, 8'h91, 8'h13, 8'h93, 8'h55};
    // outs = {i2c, slew limit, smbus, sample at end, tx on rising}
    row_t rows [9] = '{'{8'h20, 8'hc0, 8'hc0, 5'b00011}, '{8'h30, 8'h40, 8'h40, 5'b00000},
        '{8'h35, 8'h3f, 8'h00, 5'b00001}, '{8'h26, 8'hff, 8'hc0, 5'b10100},
        '{8'h28, 8'h00, 8'h00, 5'b11000}, '{8'h2f, 8'h80, 8'h80, 5'b10000},
        '{8'h27, 8'h40, 8'h40, 5'b11100}, '{8'h2b, 8'hc0, 8'hc0, 5'b10100},
        '{8'h2e, 8'h00, 8'h00, 5'b11000}};
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #5.3;
        forever #16 lclk = ~lclk;
    end
    i2c_ctrl_model far (.o_scl(scl), .o_sda(sda));
    sync_serial_port_status uut (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr_s), .I_REG_RD(rd_s), .O_REG_RDATA(rdata),
        .I_LINK_CLK(lclk), .I_SCL(scl), .I_SDA(sda), .O_I2C_MODE(outs[4]),
        .O_SLEW_LIMIT_EN(outs[3]), .O_SMBUS_LEVELS(outs[2]), .O_SAMPLE_AT_END(outs[1]),
        .O_TX_ON_RISING(outs[0]), .O_PORT_BUSY(busy));
    // --------------------------------------------------------------
    // bus tasks and checking
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask
    // link events need under 150 ns to reach the status register
    task automatic settle();
        repeat (100) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        // reset spans several link clocks so the link side is cleared too
        repeat (40) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        chk({3'b000, outs}, 8'h00);
        wr(8'h55, 8'hff);
        foreach (probe[i]) begin
            rd(probe[i]);
            chk(v, 8'h00);
        end
        $display("reset and unmapped test done");
        foreach (rows[i]) begin
            wr(`OFS_CTRL, rows[i].ctl);
            wr(`OFS_STAT, rows[i].st);
            rd(`OFS_STAT);
            chk(v, rows[i].exp);
            chk({3'b000, outs}, {3'b000, rows[i].outs});
        end
        $display("mode table test done");
        // spi receive sampled on the rising edge; the frame opens with the clock pulled low
        wr(`OFS_CTRL, 8'h20);
        settle();
        far.start_cond();
        far.send_bits(8'h5a);
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h01);
        rd(`OFS_BUF);
        chk(v, 8'h5a);
        far.stop_cond();
        $display("spi receive test done");
        wr(`OFS_CTRL, 8'h28);
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_CTRL2, (i < 5) ? 8'h01 << i : 8'h00);
            repeat (2) @(posedge clk);
            #1;
            chk({7'h00, busy}, {7'h00, i < 5});
        end
        wr(`OFS_BUF, 8'ha5);
        rd(`OFS_STAT);
        chk(v, 8'h05);
        far.start_cond();
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h0d);
        far.send_bits(8'ha5);
        settle();
        rd(`OFS_STAT);
        chk(v & 8'h05, 8'h00);
        far.ack_bit(1'b0);
        far.stop_cond();
        settle();
        rd(`OFS_STAT);
        chk(v & 8'h1c, 8'h10);
        wr(`OFS_CTRL, 8'h08);
        rd(`OFS_STAT);
        chk(v & 8'h18, 8'h00);
        $display("master transmit test done");
        far.half = 320;
        wr(`OFS_CTRL, 8'h26);
        wr(`OFS_OWN_ADDR, 8'ha0);
        far.start_cond();
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h08);
        far.send_bits(8'ha1);
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h0d);
        rd(`OFS_BUF);
        chk(v, 8'ha1);
        rd(`OFS_STAT);
        chk(v, 8'h0c);
        far.ack_bit(1'b0);
        far.send_bits(8'h3c);
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h2d);
        far.ack_bit(1'b1);
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h29);
        far.stop_cond();
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h31);
        wr(`OFS_CTRL, 8'h06);
        rd(`OFS_STAT);
        chk(v & 8'h18, 8'h00);
        $display("slave receive test done");
        far.half = 160;
        wr(`OFS_CTRL, 8'h27);
        wr(`OFS_OWN_ADDR, 8'hf2);
        far.start_cond();
        far.send_bits(8'hf2);
        settle();
        rd(`OFS_STAT);
        chk(v, 8'h0b);
        wr(`OFS_OWN_ADDR, 8'hf2);
        rd(`OFS_STAT);
        chk(v, 8'h09);
        far.ack_bit(1'b0);
        far.stop_cond();
        $display("ten bit address test done");
        report_and_stop();
    end
endmodule // test_sync_serial_port_status
`default_nettype wire
